/* core/ssp_pkg.sv */
// Shared constants, types and helpers for the synchronous serial port
package ssp_pkg;

  // ----------------------------------------------------------------
  // Frame and buffer geometry
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 3;
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] FIFO_HALF = 4'h4;
  localparam logic [3:0] LEN_M1_MIN = 4'h3;

  // ----------------------------------------------------------------
  // Timing: system clock and serial clock generated as master
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 64;
  localparam int BIT_CYCLES = SCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] TICK_LAST = 3'(BIT_CYCLES - 1);
  localparam logic [2:0] TICK_RISE = 3'(BIT_CYCLES / 2 - 1);
  localparam int RX_TIMEOUT_BITS = 32;
  localparam logic [8:0] RX_TIMEOUT_CYCLES = 9'(RX_TIMEOUT_BITS * BIT_CYCLES / 4 * 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_SPI = 2'h0,
    FMT_SSI = 2'h1,
    FMT_LEGACY = 2'h2
  } fmt_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_LEAD = 2'h1,
    M_SHIFT = 2'h3,
    M_TRAIL = 2'h2
  } m_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Frame length minus one, held at four bits or more
  function automatic logic [3:0] len_clamp(input logic [3:0] len_m1);
    len_clamp = (len_m1 < LEN_M1_MIN) ? LEN_M1_MIN : len_m1;
  endfunction

  // Bit of a word at a run-time position
  function automatic logic bit_at(input logic [15:0] word, input logic [3:0] idx);
    bit_at = word[idx];
  endfunction

endpackage

/* core/frame_store.sv */
// Eight-word frame memory with registered read data
`timescale 1ns/1ps
module frame_store (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Write side
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [15:0] i_wdata,
  // Read side
  input wire logic [2:0] i_raddr,
  output logic [15:0] o_rdata
);

  logic [15:0] mem [0:7];

  // Storage write
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data leaves through a register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= ssp_pkg::WORD_RESET;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

/* core/sync_serial_port.sv */
// Synchronous serial port: master or slave, SPI, SSI and legacy formats
//
// Notes on behaviour
// - Role is master or slave
// - Eight-frame transmit and receive buffers
// - Frame length four to sixteen bits
// - SPI, SSI or legacy format selectable
// - One master and one slave per transfer
// - Each frame moves both directions together
// - Master makes clock, slave only receives it
// - Clock polarity programmable only in SPI and only as master; the slave always uses the rising edge
// - Clock toggles only during a frame
// - Select asserted before data, released after; the SSI sync pulse ends as data starts
// - Select polarity follows the format
// - Slave uses select to qualify data
// - Slave drives MISO, master samples it
// - Master drives MOSI, slave samples it
// - Unselected slave leaves MISO undriven
// - One interrupt for four buffer conditions
`timescale 1ns/1ps
module sync_serial_port (
  // Clocks and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_SCLK,
  // Configuration
  input wire logic I_ENABLE,
  input wire logic I_MASTER,
  input wire logic [1:0] I_FORMAT,
  input wire logic I_CPOL,
  input wire logic [3:0] I_LEN_M1,
  input wire logic [3:0] I_INT_EN,
  input wire logic I_CLR_OVERRUN,
  // Transmit stream
  input wire logic I_TX_VALID,
  input wire logic [15:0] I_TX_DATA,
  output logic O_TX_READY,
  // Receive stream
  output logic O_RX_VALID,
  output logic [15:0] O_RX_DATA,
  input wire logic I_RX_READY,
  // Status
  output logic O_TX_EMPTY,
  output logic O_TX_HALF_EMPTY,
  output logic O_RX_FULL,
  output logic O_RX_HALF_FULL,
  output logic O_RX_TIMEOUT,
  output logic O_OVERRUN,
  output logic O_BUSY,
  output logic O_INT,
  // Serial pins
  output logic O_SCLK,
  output logic O_SCLK_OE,
  input wire logic I_SEL,
  output logic O_SEL,
  output logic O_SEL_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE
);

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic master_on;
  logic slave_on;
  logic fmt_ssi;
  logic idle_lvl;
  logic [3:0] len_m1;

  assign master_on = I_ENABLE && I_MASTER;
  assign slave_on = I_ENABLE && !I_MASTER;
  assign fmt_ssi = (I_FORMAT == ssp_pkg::FMT_SSI);
  assign idle_lvl = (I_FORMAT == ssp_pkg::FMT_SPI) ? I_CPOL : 1'b0;
  assign len_m1 = ssp_pkg::len_clamp(I_LEN_M1);

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  logic [2:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [3:0] tx_cnt, rx_cnt;
  logic tx_avail, rx_avail;
  logic tx_push, tx_pop, rx_req, rx_push, rx_pop;
  logic [15:0] tx_rdata, rx_wdata;

  assign O_TX_READY = (tx_cnt != ssp_pkg::FIFO_DEPTH);
  assign tx_push = I_TX_VALID && O_TX_READY;
  assign rx_push = rx_req && (rx_cnt != ssp_pkg::FIFO_DEPTH);
  assign O_RX_VALID = rx_avail;
  assign rx_pop = I_RX_READY && rx_avail;

  frame_store u_tx_store (
    .i_clock(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_we(tx_push),
    .i_waddr(tx_wp),
    .i_wdata(I_TX_DATA),
    .i_raddr(tx_rp),
    .o_rdata(tx_rdata)
  );

  frame_store u_rx_store (
    .i_clock(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_we(rx_push),
    .i_waddr(rx_wp),
    .i_wdata(rx_wdata),
    .i_raddr(rx_rp),
    .o_rdata(O_RX_DATA)
  );

  // Pointers and fill counts; read data settles a cycle after a move
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
      tx_cnt <= 4'h0;
      rx_cnt <= 4'h0;
      tx_avail <= 1'b0;
      rx_avail <= 1'b0;
    end else begin
      tx_wp <= tx_wp + 3'(tx_push);
      tx_rp <= tx_rp + 3'(tx_pop);
      rx_wp <= rx_wp + 3'(rx_push);
      rx_rp <= rx_rp + 3'(rx_pop);
      tx_cnt <= tx_cnt + 4'(tx_push) - 4'(tx_pop);
      rx_cnt <= rx_cnt + 4'(rx_push) - 4'(rx_pop);
      tx_avail <= (tx_cnt != 4'h0) && !tx_pop;
      rx_avail <= (rx_cnt != 4'h0) && !rx_pop;
    end
  end

  // Fill flags
  assign O_TX_EMPTY = (tx_cnt == 4'h0);
  assign O_TX_HALF_EMPTY = (tx_cnt <= ssp_pkg::FIFO_HALF);
  assign O_RX_FULL = (rx_cnt == ssp_pkg::FIFO_DEPTH);
  assign O_RX_HALF_FULL = (rx_cnt >= ssp_pkg::FIFO_HALF);

  // ----------------------------------------------------------------
  // Inputs from the pins and from the link domain
  // ----------------------------------------------------------------
  logic [2:0] sy1, sy2, sy3, filt, next_filt;
  logic lk_take_tgl, lk_done_tgl;
  logic miso_f, take_ev, done_ev;

  // Three stages per input; a change counts once stages two and three agree
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sy3 <= 3'h0;
      filt <= 3'h0;
    end else begin
      sy1 <= {lk_done_tgl, lk_take_tgl, I_MISO};
      sy2 <= sy1;
      sy3 <= sy2;
      filt <= next_filt;
    end
  end

  // Accepted values and toggle events
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 3; i++) begin
      if (sy2[i] == sy3[i]) begin
        next_filt[i] = sy3[i];
      end
    end
  end

  assign miso_f = next_filt[0]; // Agreed value, so each rise sees the bit just launched
  assign take_ev = next_filt[1] != filt[1];
  assign done_ev = next_filt[2] != filt[2];

  // ----------------------------------------------------------------
  // Master engine: makes the serial clock from the system clock
  // ----------------------------------------------------------------
  ssp_pkg::m_state_t m_state;
  logic [2:0] m_tick;
  logic [3:0] m_bit;
  logic [15:0] m_tx, m_rx;
  logic m_go, m_rise, m_end;

  assign m_go = master_on && (m_state == ssp_pkg::M_IDLE) && tx_avail;
  assign m_rise = (m_state == ssp_pkg::M_SHIFT) && (m_tick == ssp_pkg::TICK_RISE);
  assign m_end = (m_state == ssp_pkg::M_SHIFT) && (m_tick == ssp_pkg::TICK_LAST) && (m_bit == len_m1);

  // Frame sequence: lead-in with select, data bits, trailing half bit
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      m_state <= ssp_pkg::M_IDLE;
      m_tick <= 3'h0;
      m_bit <= 4'h0;
    end else if (!master_on) begin
      m_state <= ssp_pkg::M_IDLE;
      m_tick <= 3'h0;
      m_bit <= 4'h0;
    end else begin
      m_tick <= (m_state == ssp_pkg::M_IDLE) ? 3'h0 : m_tick + 3'h1;
      unique case (m_state)
        ssp_pkg::M_IDLE: begin
          if (m_go) begin
            m_state <= ssp_pkg::M_LEAD;
            m_bit <= 4'h0;
          end
        end
        ssp_pkg::M_LEAD: begin
          if (m_tick == ssp_pkg::TICK_LAST) begin
            m_state <= ssp_pkg::M_SHIFT;
          end
        end
        ssp_pkg::M_SHIFT: begin
          if (m_tick == ssp_pkg::TICK_LAST) begin
            if (m_bit == len_m1) begin
              m_state <= ssp_pkg::M_TRAIL;
            end else begin
              m_bit <= m_bit + 4'h1;
            end
          end
        end
        ssp_pkg::M_TRAIL: begin
          if (m_tick == ssp_pkg::TICK_RISE) begin
            m_state <= ssp_pkg::M_IDLE;
          end
        end
      endcase
    end
  end

  // Master shift registers: MOSI moves on the trailing clock edge, MISO caught at the leading edge
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      m_tx <= ssp_pkg::WORD_RESET;
      m_rx <= ssp_pkg::WORD_RESET;
    end else if (m_go) begin
      m_tx <= tx_rdata;
      m_rx <= ssp_pkg::WORD_RESET;
    end else begin
      if (m_rise) begin
        m_rx <= {m_rx[14:0], miso_f};
      end
      if ((m_state == ssp_pkg::M_SHIFT) && (m_tick == ssp_pkg::TICK_LAST)) begin
        m_tx <= {m_tx[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave hand-over word and receive path
  // ----------------------------------------------------------------
  logic [15:0] hold, lk_rx_word;
  logic hold_full, hold_load;

  assign hold_load = slave_on && !hold_full && tx_avail && !take_ev;
  assign tx_pop = m_go || hold_load;
  assign rx_req = m_end || (slave_on && done_ev);
  assign rx_wdata = m_end ? m_rx : lk_rx_word;

  // Word for the next slave frame; zeros go out if none is ready
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      hold <= ssp_pkg::WORD_RESET;
      hold_full <= 1'b0;
    end else if (take_ev || !slave_on) begin
      hold <= ssp_pkg::WORD_RESET;
      hold_full <= 1'b0;
    end else if (hold_load) begin
      hold <= tx_rdata;
      hold_full <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt conditions
  // ----------------------------------------------------------------
  logic [8:0] to_cnt;

  // Receive idle time while words wait unread
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      to_cnt <= 9'h000;
    end else if (rx_push || rx_pop || (rx_cnt == 4'h0)) begin
      to_cnt <= 9'h000;
    end else if (to_cnt != ssp_pkg::RX_TIMEOUT_CYCLES) begin
      to_cnt <= to_cnt + 9'h001;
    end
  end

  // Overrun stays until cleared; a new overrun beats the clear
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_OVERRUN <= 1'b0;
    end else if (rx_req && !rx_push) begin
      O_OVERRUN <= 1'b1;
    end else if (I_CLR_OVERRUN) begin
      O_OVERRUN <= 1'b0;
    end
  end

  assign O_RX_TIMEOUT = (to_cnt == ssp_pkg::RX_TIMEOUT_CYCLES);
  assign O_INT = |(I_INT_EN & {O_OVERRUN, O_RX_TIMEOUT, O_RX_HALF_FULL, O_TX_HALF_EMPTY});
  assign O_BUSY = (m_state != ssp_pkg::M_IDLE) || hold_full;

  // ----------------------------------------------------------------
  // Slave engine on the incoming serial clock
  // ----------------------------------------------------------------
  logic [5:0] lk_c1, lk_c2, lk_c3, lk_cfg;
  logic lk_on, lk_ssi, lk_bit_en, lk_frame, lk_last;
  logic [3:0] lk_len, lk_cnt;
  logic [15:0] lk_sh, lk_tx;

  // Configuration is static during traffic; three stages plus agreement
  always_ff @(posedge I_SCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lk_c1 <= ssp_pkg::CFG_RESET;
      lk_c2 <= ssp_pkg::CFG_RESET;
      lk_c3 <= ssp_pkg::CFG_RESET;
      lk_cfg <= ssp_pkg::CFG_RESET;
    end else begin
      lk_c1 <= {slave_on, fmt_ssi, len_m1};
      lk_c2 <= lk_c1;
      lk_c3 <= lk_c2;
      if (lk_c2 == lk_c3) begin
        lk_cfg <= lk_c3;
      end
    end
  end

  assign lk_on = lk_cfg[5];
  assign lk_ssi = lk_cfg[4];
  assign lk_len = lk_cfg[3:0];
  assign lk_last = (lk_cnt == lk_len);
  assign lk_bit_en = lk_on && (lk_ssi ? lk_frame : !I_SEL);

  // SSI frame: a high sync pulse opens the frame on the following edge
  always_ff @(posedge I_SCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lk_frame <= 1'b0;
    end else if (!lk_on || !lk_ssi) begin
      lk_frame <= 1'b0;
    end else if (I_SEL && (!lk_frame || lk_last)) begin
      lk_frame <= 1'b1;
    end else if (lk_frame && lk_last) begin
      lk_frame <= 1'b0;
    end
  end

  // Slave shift: sample MOSI, advance MISO, hand the word back at the end
  always_ff @(posedge I_SCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lk_cnt <= 4'h0;
      lk_sh <= ssp_pkg::WORD_RESET;
      lk_tx <= ssp_pkg::WORD_RESET;
      lk_rx_word <= ssp_pkg::WORD_RESET;
      lk_take_tgl <= 1'b0;
      lk_done_tgl <= 1'b0;
    end else if (lk_bit_en) begin
      if (lk_cnt == 4'h0) begin
        lk_sh <= {15'h0000, I_MOSI};
        lk_tx <= {hold[14:0], 1'b0};
        lk_take_tgl <= !lk_take_tgl;
      end else begin
        lk_sh <= {lk_sh[14:0], I_MOSI};
        lk_tx <= {lk_tx[14:0], 1'b0};
      end
      if (lk_last) begin
        lk_cnt <= 4'h0;
        lk_rx_word <= {lk_sh[14:0], I_MOSI};
        lk_done_tgl <= !lk_done_tgl;
      end else begin
        lk_cnt <= lk_cnt + 4'h1;
      end
    end else if (!lk_ssi) begin
      lk_cnt <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign O_SCLK_OE = master_on;
  assign O_SCLK = idle_lvl ^ ((m_state == ssp_pkg::M_SHIFT) && m_tick[2]);
  assign O_SEL_OE = master_on;
  assign O_SEL = fmt_ssi ? (m_state == ssp_pkg::M_LEAD) : (m_state == ssp_pkg::M_IDLE);
  assign O_MOSI_OE = master_on;
  assign O_MOSI = ssp_pkg::bit_at(m_tx, len_m1);
  assign O_MISO_OE = slave_on && (fmt_ssi ? lk_frame : !I_SEL);
  assign O_MISO = (lk_cnt == 4'h0) ? ssp_pkg::bit_at(hold, lk_len) : ssp_pkg::bit_at(lk_tx, lk_len);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] m_rises;

  // Serial clock rises counted within a master frame
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      m_rises <= 5'h00;
    end else if (m_state == ssp_pkg::M_LEAD) begin
      m_rises <= 5'h00;
    end else if (m_rise) begin
      m_rises <= m_rises + 5'h01;
    end
  end

  sequence lead_phase;
    (m_state == ssp_pkg::M_LEAD && O_SCLK == idle_lvl)[*8];
  endsequence

  sequence first_bit;
    (m_state == ssp_pkg::M_SHIFT) ##4 (O_SCLK != idle_lvl);
  endsequence

  AST_LEAD_THEN_CLOCK: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (m_go && I_ENABLE && I_MASTER) |=> lead_phase ##1 first_bit)
    else $error("select lead-in or first clock wrong");

  AST_FRAME_BITS: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    $rose(m_state == ssp_pkg::M_TRAIL) |-> (m_rises == 5'(len_m1) + 5'h01))
    else $error("clock rises do not match frame length");

  AST_CLOCK_IDLE: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (master_on && m_state != ssp_pkg::M_SHIFT) |-> (O_SCLK == idle_lvl))
    else $error("serial clock moved outside a frame");

  AST_FIXED_POLARITY: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (master_on && I_FORMAT != ssp_pkg::FMT_SPI && m_state == ssp_pkg::M_IDLE) |-> !O_SCLK)
    else $error("non-SPI clock not idle low");

  AST_SELECT_LEVEL: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (master_on && m_state == ssp_pkg::M_IDLE) |-> (O_SEL == !fmt_ssi))
    else $error("idle select level wrong for format");

  AST_MISO_RELEASED: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (slave_on && !fmt_ssi && I_SEL) |-> !O_MISO_OE)
    else $error("unselected slave drives MISO");

  AST_ROLE_DRIVERS: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    master_on |-> (O_MOSI_OE && O_SCLK_OE && !O_MISO_OE))
    else $error("master pin drivers wrong");

  AST_FIFO_BOUND: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (tx_cnt <= ssp_pkg::FIFO_DEPTH) && (rx_cnt <= ssp_pkg::FIFO_DEPTH))
    else $error("buffer count beyond eight");

  AST_OVERRUN_SETS: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (rx_req && O_RX_FULL && !rx_pop) |=> (O_OVERRUN && $stable(rx_cnt)))
    else $error("overrun not flagged on full receive buffer");

  AST_SLAVE_COUNT: assert property (@(posedge I_SCLK) disable iff (I_SYS_RST)
    (lk_bit_en && lk_last) |=> (lk_cnt == 4'h0) && (lk_done_tgl != $past(lk_done_tgl)))
    else $error("slave frame end not handed over");

endmodule

/* test/ssp_partner.sv */
// Far-side model of the link: responding slave and clock-making master
`timescale 1ns/1ps
module ssp_partner (
  // Link as seen on the wires
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_cpol,
  // Driven by the model
  output logic o_miso,
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_mosi
);
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  int nbits = 8;
  int cnt = 0;
  wire act = i_sclk ^ i_cpol;

  // ---------------------------------------------------------
  // Slave side
  // ---------------------------------------------------------
  initial begin
    o_miso = 1'b0;
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_mosi = 1'b0;
  end
  // First bit ready as soon as selected
  always @(negedge i_sel_n) begin
    cnt = nbits - 1;
    o_miso = tx_word[cnt];
  end
  // Sample master data on the leading clock edge
  always @(posedge act) if (!i_sel_n) rx_word = {rx_word[14:0], i_mosi};
  // Next bit on the trailing edge
  always @(negedge act) if (!i_sel_n && cnt > 0) begin
    cnt = cnt - 1;
    o_miso = tx_word[cnt];
  end
  // Released line no longer shows the last bit
  always @(posedge i_sel_n) o_miso = ~o_miso;

  // ---------------------------------------------------------
  // Master side: clock pulses once per bit, with select held at the level given
  // ---------------------------------------------------------
  task automatic run_master(input logic [15:0] w, input int n, input logic s, output logic [15:0] r);
    r = 16'h0000;
    #3.3;
    o_sel_n = s;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = w[i];
      #32;
      r = {r[14:0], i_miso};
      o_sclk = 1'b1;
      #32;
      o_sclk = 1'b0;
    end
    #32;
    o_sel_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule

/* test/tb_sync_serial_port.sv */
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module tb_sync_serial_port;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, mst = 1'b0, cpol = 1'b0, pol = 1'b0;
  logic tx_v = 1'b0, rx_r = 1'b0, clr = 1'b0, seen = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [3:0] lenm1 = 4'h7, ien = 4'h0;
  logic [15:0] tx_d = 16'h0000, rx_d;
  logic tx_rdy, rx_v, tx_e, tx_he, rx_full, rx_hf, rx_to, ovr, busy, irq;
  logic sclk_o, sclk_oe, sel_o, sel_oe, miso_o, miso_oe, mosi_o, mosi_oe;
  logic p_miso, p_sclk, p_sel, p_mosi, sclk_l, sel_l, miso_l, mosi_l;
  int err_count = 0;
  int cmp_count = 0;
  int stray = 0;

  // ---------------------------------------------------------
  // Clock, wires and instances
  // ---------------------------------------------------------
  always #4 clk = ~clk;
  // Each line follows whichever party enables its driver
  assign sclk_l = sclk_oe ? sclk_o : p_sclk;
  assign sel_l = sel_oe ? sel_o : p_sel;
  assign miso_l = miso_oe ? miso_o : p_miso;
  assign mosi_l = mosi_oe ? mosi_o : p_mosi;
  // Clock edges while select is idle in master mode
  always @(sclk_l) if (mst && fmt != 2'h1 && sel_l === 1'b1) stray++;

  sync_serial_port dut_u (.I_CLOCK(clk), .I_SYS_RST(rst), .I_SCLK(sclk_l), .I_ENABLE(en), .I_MASTER(mst),
    .I_FORMAT(fmt), .I_CPOL(cpol), .I_LEN_M1(lenm1), .I_INT_EN(ien), .I_CLR_OVERRUN(clr),
    .I_TX_VALID(tx_v), .I_TX_DATA(tx_d), .O_TX_READY(tx_rdy), .O_RX_VALID(rx_v), .O_RX_DATA(rx_d),
    .I_RX_READY(rx_r), .O_TX_EMPTY(tx_e), .O_TX_HALF_EMPTY(tx_he), .O_RX_FULL(rx_full),
    .O_RX_HALF_FULL(rx_hf), .O_RX_TIMEOUT(rx_to), .O_OVERRUN(ovr), .O_BUSY(busy), .O_INT(irq),
    .O_SCLK(sclk_o), .O_SCLK_OE(sclk_oe), .I_SEL(sel_l), .O_SEL(sel_o), .O_SEL_OE(sel_oe),
    .I_MISO(miso_l), .O_MISO(miso_o), .O_MISO_OE(miso_oe), .I_MOSI(mosi_l), .O_MOSI(mosi_o),
    .O_MOSI_OE(mosi_oe));

  ssp_partner p_u (.i_sclk(sclk_l), .i_sel_n(sel_l), .i_mosi(mosi_l), .i_miso(miso_l), .i_cpol(pol),
    .o_miso(p_miso), .o_sclk(p_sclk), .o_sel_n(p_sel), .o_mosi(p_mosi));

  // ---------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    tally_and_finish();
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    check(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic push(input logic [15:0] w);
    tx_v = 1'b1;
    tx_d = w;
    step();
    tx_v = 1'b0;
    step();
  endtask
  task automatic pop(output logic [15:0] w);
    int i;
    for (i = 0; i < 4000 && rx_v !== 1'b1; i++) begin
      if (sel_l === (fmt == 2'h1)) seen = 1'b1;
      step();
    end
    if (rx_v !== 1'b1) give_up();
    w = rx_d;
    rx_r = 1'b1;
    step();
    rx_r = 1'b0;
    step();
  endtask
  task automatic idle_wait();
    int i;
    repeat (3) step();
    for (i = 0; i < 4000 && (busy !== 1'b0 || tx_e !== 1'b1); i++) step();
    if (busy !== 1'b0 || tx_e !== 1'b1) give_up();
  endtask

  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task automatic sc_master(input logic [1:0] f, input logic c, input logic [3:0] l, input logic [15:0] w, rep);
    logic [15:0] got, mask;
    int n;
    n = (l < 4'h3) ? 4 : int'(l) + 1;
    mask = 16'hffff >> (16 - n);
    fmt = f;
    cpol = c;
    lenm1 = l;
    mst = 1'b1;
    en = 1'b1;
    pol = (f == 2'h0) ? c : 1'b0;
    p_u.tx_word = rep;
    p_u.nbits = n;
    repeat (4) step();
    check1("sclk_idle", pol, sclk_l);
    stray = 0;
    seen = 1'b0;
    push(w);
    pop(got);
    idle_wait();
    check("rx_word", rep & mask, got & mask);
    check("slave_word", w & mask, p_u.rx_word & mask);
    check1("sel_seen", 1'b1, seen);
    check1("sel_idle", f != 2'h1, sel_l);
    check("stray_edges", 16'h0000, 16'(stray));
  endtask

  task automatic sc_slave(input logic [1:0] f);
    logic [15:0] got, w;
    fmt = f;
    cpol = 1'b0;
    pol = 1'b0;
    lenm1 = 4'h7;
    mst = 1'b0;
    en = 1'b0;
    // Idle clocks carry the new setup into the link domain, port off first
    p_u.run_master(16'h0000, 8, 1'b1, got);
    en = 1'b1;
    push(16'h00c9);
    p_u.run_master(16'h0000, 8, f != 2'h1, got);
    repeat (4) step();
    check1("miso_oe_idle", 1'b0, miso_oe);
    check1("sclk_oe_slave", 1'b0, sclk_oe);
    // One edge with select high: opens an SSI frame, ignored otherwise
    p_u.run_master(16'h0000, 1, 1'b1, got);
    p_u.run_master(16'h0096, 8, 1'b0, got);
    step();
    check("master_word", 16'h00c9, got & 16'h00ff);
    pop(w);
    check("slave_rx", 16'h0096, w & 16'h00ff);
    check1("miso_oe_off", 1'b0, miso_oe);
  endtask

  task automatic sc_fill();
    logic [15:0] got;
    en = 1'b0;
    mst = 1'b1;
    fmt = 2'h0;
    ien = 4'hf;
    p_u.tx_word = 16'h0011;
    p_u.nbits = 8;
    for (int k = 0; k < 8; k++) push(16'(k));
    check1("tx_ready_full", 1'b0, tx_rdy);
    check1("tx_half_empty", 1'b0, tx_he);
    check1("int_none", 1'b0, irq);
    push(16'h00ff);
    en = 1'b1;
    idle_wait();
    check("last_sent", 16'h0007, p_u.rx_word & 16'h00ff);
    check1("rx_full", 1'b1, rx_full);
    check1("int_half_full", 1'b1, irq);
    push(16'h0055);
    idle_wait();
    repeat (8) step();
    ien = 4'h8;
    step();
    check1("overrun", 1'b1, ovr);
    check1("int_overrun", 1'b1, irq);
    clr = 1'b1;
    step();
    clr = 1'b0;
    step();
    check1("int_cleared", 1'b0, irq);
    ien = 4'h4;
    repeat (300) step();
    check1("rx_timeout", 1'b1, rx_to);
    check1("int_timeout", 1'b1, irq);
    for (int k = 0; k < 8; k++) begin
      pop(got);
      check("rx_fifo", 16'h0011, got & 16'h00ff);
    end
    check1("rx_drained", 1'b0, rx_v);
    check1("rx_half_drained", 1'b0, rx_hf);
  endtask

  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    step();
    check1("tx_empty_rst", 1'b1, tx_e);
    check1("tx_ready_rst", 1'b1, tx_rdy);
    sc_master(2'h0, 1'b0, 4'h7, 16'h00a5, 16'h003c);
    sc_master(2'h0, 1'b1, 4'hf, 16'hb1e7, 16'h5a96);
    sc_master(2'h1, 1'b0, 4'h1, 16'h000d, 16'h0006);
    sc_master(2'h2, 1'b1, 4'hb, 16'h0c35, 16'h0a3f);
    sc_slave(2'h0);
    sc_slave(2'h1);
    sc_fill();
    tally_and_finish();
  end
endmodule
